// ### tcp_regs.vh
// Purpose: register map, field positions and reset values of the timer/counter/pwm
// Assumes: 32-bit AXI4-Lite slave, one aligned word per register
// Notes:   definitions only
`ifndef TCP_REGS_VH
`define TCP_REGS_VH
// ************************************
// register byte offsets
// ************************************
`define TCP_OFF_CTRL     8'h00
`define TCP_OFF_PERIOD   8'h04
`define TCP_OFF_CMP      8'h08
`define TCP_OFF_COUNT    8'h0C
`define TCP_OFF_CAPTURE  8'h10
`define TCP_OFF_DEADBAND 8'h14
`define TCP_OFF_STATUS   8'h18
`define TCP_OFF_MASK     8'h1C
// ************************************
// control fields
// ************************************
`define TCP_CTRL_RUN      0
`define TCP_CTRL_MODE_LO  1
`define TCP_CTRL_MODE_HI  2
`define TCP_CTRL_CMP_LO   3
`define TCP_CTRL_CMP_HI   5
`define TCP_CTRL_CLK_LO   6
`define TCP_CTRL_CLK_HI   7
`define TCP_CTRL_TCSEL    8
`define TCP_CTRL_RST      16'h0000
// ************************************
// run modes, compare relations, clock sources
// ************************************
`define TCP_MODE_FREE     2'h0
`define TCP_MODE_ONESHOT  2'h1
`define TCP_MODE_GATED    2'h2
`define TCP_CMP_LT        3'h0
`define TCP_CMP_LTE       3'h1
`define TCP_CMP_EQ        3'h2
`define TCP_CMP_GTE       3'h3
`define TCP_CMP_GT        3'h4
`define TCP_CLK_SYS       2'h0
`define TCP_CLK_DIV2      2'h1
`define TCP_CLK_DIV16     2'h2
`define TCP_CLK_EXT       2'h3
// ************************************
// status bits, reset values
// ************************************
`define TCP_ST_TC         0
`define TCP_ST_CMP        1
`define TCP_ST_CAP        2
`define TCP_PERIOD_RST    16'hFFFF
`define TCP_CMP_RST       16'h8000
`define TCP_DB_RST        8'h02
`define TCP_DIV16_LAST    4'hF
`endif

// ### tcp_sync2.v
// Purpose: two flip-flop synchroniser for one pin level
// Assumes: sys_clk domain, resetn asynchronous active low
// Notes:   first stage read only by the second
module tcp_sync2 (
   // clock and reset
   input  wire sys_clk,
   input  wire resetn,
   // level
   input  wire pinIn,
   output wire syncOut
);
   reg stage1_r;
   reg stage2_r;
   // two stage capture
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         stage1_r <= 1'b0;
         stage2_r <= 1'b0;
      end else begin
         stage1_r <= pinIn;
         stage2_r <= stage1_r;
      end
   end
   assign syncOut = stage2_r;
endmodule

// ### tcp_timer.v
// Purpose: 16-bit down-counting timer, counter and pwm with axi4-lite registers
// Assumes: one clock sys_clk at 25 MHz; routed inputs arrive asynchronously
// Notes:   slower count clocks are one-cycle enables, never real clocks
//
// How it works
// - 16-bit counter only ever counts down
// - count clock picked from four sources
// - compare relation selectable, drives compare output
// - period reload on start, reset, terminal count
// - compare, terminal count or inverted compare, interrupt outputs
// - interrupt from terminal count, compare, capture
// - free running, one shot, enable-gated modes
// - one shot stops at end of period
// - gated mode counts only while enable high
// - reset and capture inputs; capture stores count
// - kill input forces pwm outputs off
// - complementary pwm pair with deadband gap
`include "tcp_regs.vh"
module tcp_timer (
   // clock and reset
   input  wire        sys_clk,
   input  wire        resetn,
   // axi4-lite write address
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read address
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // axi4-lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // routed inputs
   input  wire        timerEnable,
   input  wire        timerReset,
   input  wire        captureIn,
   input  wire        killIn,
   input  wire        extClock,
   // routed outputs
   output reg         cmpOut,
   output reg         tcOut,
   output reg         pwmHigh,
   output reg         pwmLow,
   output wire        irq
);
   // ************************************
   // input synchronisers
   // ************************************
   wire enS;
   wire rstS;
   wire capS;
   wire killS;
   wire extS;
   tcp_sync2 uSyncEn   (.sys_clk(sys_clk), .resetn(resetn), .pinIn(timerEnable), .syncOut(enS));
   tcp_sync2 uSyncRst  (.sys_clk(sys_clk), .resetn(resetn), .pinIn(timerReset),  .syncOut(rstS));
   tcp_sync2 uSyncCap  (.sys_clk(sys_clk), .resetn(resetn), .pinIn(captureIn),   .syncOut(capS));
   tcp_sync2 uSyncKill (.sys_clk(sys_clk), .resetn(resetn), .pinIn(killIn),      .syncOut(killS));
   tcp_sync2 uSyncExt  (.sys_clk(sys_clk), .resetn(resetn), .pinIn(extClock),    .syncOut(extS));

   // ************************************
   // registers
   // ************************************
   reg [15:0] ctrl_r;
   reg [15:0] period_r;
   reg [15:0] cmpVal_r;
   reg [15:0] count_r;
   reg [15:0] capture_r;
   reg [7:0]  deadband_r;
   reg [2:0]  status_r;
   reg [2:0]  mask_r;
   reg        running_r;
   reg        runPrev_r;
   reg        capPrev_r;
   reg        rstPrev_r;
   reg        extPrev_r;
   reg [3:0]  div_r;
   reg        cmpPrev_r;
   reg [7:0]  dbCnt_r;
   reg        pwmState_r;

   wire [1:0] mode   = ctrl_r[`TCP_CTRL_MODE_HI:`TCP_CTRL_MODE_LO];
   wire [2:0] rel    = ctrl_r[`TCP_CTRL_CMP_HI:`TCP_CTRL_CMP_LO];
   wire [1:0] clkSel = ctrl_r[`TCP_CTRL_CLK_HI:`TCP_CTRL_CLK_LO];
   wire       runBit = ctrl_r[`TCP_CTRL_RUN];

   // ************************************
   // count clock enable
   // ************************************
   reg tick;
   always @* begin
      case (clkSel)
         `TCP_CLK_SYS:   tick = 1'b1;
         `TCP_CLK_DIV2:  tick = div_r[0];
         `TCP_CLK_DIV16: tick = (div_r == `TCP_DIV16_LAST);
         `TCP_CLK_EXT:   tick = extS & ~extPrev_r;
         default:        tick = 1'b0;
      endcase
   end

   // ************************************
   // counter core
   // ************************************
   wire startEv = runBit & ~runPrev_r;
   wire rstEv   = rstS & ~rstPrev_r;
   wire capEv   = capS & ~capPrev_r;
   wire gateOk  = (mode != `TCP_MODE_GATED) | enS;
   wire step    = running_r & tick & gateOk;
   wire atZero  = (count_r == 16'h0000);
   wire tcEv    = step & atZero;

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         count_r   <= `TCP_PERIOD_RST;
         running_r <= 1'b0;
         runPrev_r <= 1'b0;
         rstPrev_r <= 1'b0;
         capPrev_r <= 1'b0;
         extPrev_r <= 1'b0;
         div_r     <= 4'h0;
         capture_r <= 16'h0000;
         tcOut     <= 1'b0;
      end else begin
         runPrev_r <= runBit;
         rstPrev_r <= rstS;
         capPrev_r <= capS;
         extPrev_r <= extS;
         div_r     <= div_r + 4'h1;
         tcOut     <= ctrl_r[`TCP_CTRL_TCSEL] ? ~cmpOut : tcEv;
         if (capEv)
            capture_r <= count_r;
         if (!runBit) begin
            running_r <= 1'b0;
         end else if (startEv || rstEv) begin
            count_r   <= period_r;
            running_r <= 1'b1;
         end else if (tcEv) begin
            count_r <= period_r;
            if (mode == `TCP_MODE_ONESHOT)
               running_r <= 1'b0;
         end else if (step) begin
            count_r <= count_r - 16'h0001;
         end
      end
   end

   // ************************************
   // compare
   // ************************************
   reg cmpTrue;
   always @* begin
      case (rel)
         `TCP_CMP_LT:  cmpTrue = count_r <  cmpVal_r;
         `TCP_CMP_LTE: cmpTrue = count_r <= cmpVal_r;
         `TCP_CMP_EQ:  cmpTrue = count_r == cmpVal_r;
         `TCP_CMP_GTE: cmpTrue = count_r >= cmpVal_r;
         `TCP_CMP_GT:  cmpTrue = count_r >  cmpVal_r;
         default:      cmpTrue = 1'b0;
      endcase
   end

   // ************************************
   // pwm with deadband and kill
   // ************************************
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cmpOut     <= 1'b0;
         cmpPrev_r  <= 1'b0;
         pwmState_r <= 1'b0;
         dbCnt_r    <= 8'h00;
         pwmHigh    <= 1'b0;
         pwmLow     <= 1'b0;
      end else begin
         cmpOut    <= cmpTrue & ~killS;
         cmpPrev_r <= cmpTrue;
         if (cmpTrue != cmpPrev_r) begin
            pwmState_r <= cmpTrue;
            dbCnt_r    <= deadband_r;
         end else if (dbCnt_r != 8'h00) begin
            dbCnt_r <= dbCnt_r - 8'h01;
         end
         if (killS || (cmpTrue != cmpPrev_r) || (dbCnt_r != 8'h00)) begin
            pwmHigh <= 1'b0;
            pwmLow  <= 1'b0;
         end else begin
            pwmHigh <= pwmState_r;
            pwmLow  <= ~pwmState_r;
         end
      end
   end

   // ************************************
   // axi4-lite slave
   // ************************************
   reg        awHeld_r;
   reg        wHeld_r;
   reg [7:0]  awAddr_r;
   reg [31:0] wData_r;
   reg [3:0]  wStrb_r;
   assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
   assign s_axi_wready  = ~wHeld_r & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   wire [7:0]  wrAddr = awHeld_r ? awAddr_r : s_axi_awaddr;
   wire [31:0] wrData = wHeld_r ? wData_r : s_axi_wdata;
   wire [3:0]  wrStrb = wHeld_r ? wStrb_r : s_axi_wstrb;
   wire haveAw = awHeld_r | (s_axi_awvalid & s_axi_awready);
   wire haveW  = wHeld_r | (s_axi_wvalid & s_axi_wready);
   wire doWr   = haveAw & haveW;

   // byte-lane merge helper
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] dat;
      input [3:0]  stb;
      begin
         merge16 = {stb[1] ? dat[15:8] : old[15:8], stb[0] ? dat[7:0] : old[7:0]};
      end
   endfunction

   wire wrOk = (wrAddr[1:0] == 2'b00) && (wrAddr <= `TCP_OFF_MASK);
   wire [2:0] w1c = (doWr && wrAddr == `TCP_OFF_STATUS && wrStrb[0]) ? wrData[2:0] : 3'b000;
   wire [2:0] evs = {capEv, cmpTrue & ~cmpPrev_r, tcEv};

   // write side and sticky status
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         awHeld_r     <= 1'b0;
         wHeld_r      <= 1'b0;
         awAddr_r     <= 8'h00;
         wData_r      <= 32'h0000_0000;
         wStrb_r      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
         ctrl_r       <= `TCP_CTRL_RST;
         period_r     <= `TCP_PERIOD_RST;
         cmpVal_r     <= `TCP_CMP_RST;
         deadband_r   <= `TCP_DB_RST;
         mask_r       <= 3'b000;
         status_r     <= 3'b000;
      end else begin
         status_r <= (status_r & ~w1c) | evs;
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (doWr) begin
            awHeld_r     <= 1'b0;
            wHeld_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrOk ? 2'b00 : 2'b10;
            case (wrAddr)
               `TCP_OFF_CTRL:     ctrl_r     <= merge16(ctrl_r, wrData, wrStrb);
               `TCP_OFF_PERIOD:   period_r   <= merge16(period_r, wrData, wrStrb);
               `TCP_OFF_CMP:      cmpVal_r   <= merge16(cmpVal_r, wrData, wrStrb);
               `TCP_OFF_DEADBAND: if (wrStrb[0]) deadband_r <= wrData[7:0];
               `TCP_OFF_MASK:     if (wrStrb[0]) mask_r <= wrData[2:0];
               default:           ;
            endcase
         end else begin
            if (s_axi_awvalid && s_axi_awready) begin
               awHeld_r <= 1'b1;
               awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
               wHeld_r <= 1'b1;
               wData_r <= s_axi_wdata;
               wStrb_r <= s_axi_wstrb;
            end
         end
      end
   end

   // read side
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'b00;
         case (s_axi_araddr)
            `TCP_OFF_CTRL:     s_axi_rdata <= {16'h0000, ctrl_r};
            `TCP_OFF_PERIOD:   s_axi_rdata <= {16'h0000, period_r};
            `TCP_OFF_CMP:      s_axi_rdata <= {16'h0000, cmpVal_r};
            `TCP_OFF_COUNT:    s_axi_rdata <= {16'h0000, count_r};
            `TCP_OFF_CAPTURE:  s_axi_rdata <= {16'h0000, capture_r};
            `TCP_OFF_DEADBAND: s_axi_rdata <= {24'h00_0000, deadband_r};
            `TCP_OFF_STATUS:   s_axi_rdata <= {29'h0000_0000, status_r};
            `TCP_OFF_MASK:     s_axi_rdata <= {29'h0000_0000, mask_r};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // level interrupt from unmasked sticky bits
   assign irq = |(status_r & mask_r);
endmodule

// ### tcp_route_model.sv
// Purpose: routing-fabric model that drives the timer's routed inputs
// Assumes: levels commanded by the bench, changed right after sys_clk edges
// Notes:   external count clock stands low unless extRun is high
module tcp_route_model (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic resetn,
   // commands from the bench
   input  wire logic enCmd,
   input  wire logic rstCmd,
   input  wire logic capCmd,
   input  wire logic killCmd,
   input  wire logic extRun,
   // routed levels toward the timer
   output logic      timerEnable,
   output logic      timerReset,
   output logic      captureIn,
   output logic      killIn,
   output logic      extClock
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] divCnt_r;
   // ****************
   // routed levels
   // ****************
   // register commands, divide by four for the external clock
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         divCnt_r <= 2'h0;
         {timerEnable, timerReset, captureIn, killIn, extClock} <= 5'h00;
      end else begin
         divCnt_r <= divCnt_r + 2'h1;
         {timerEnable, timerReset, captureIn, killIn} <= {enCmd, rstCmd, capCmd, killCmd};
         extClock <= extRun & divCnt_r[1];
      end
   end
endmodule

// ### tcp_timer_checker.sv
// Purpose: port-level checks of bus answers, kill and pwm pair
// Assumes: one sys_clk domain, resetn asynchronous active low
// Notes:   bound to every timer instance
module tcp_timer_checker (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // routed pins
   input wire logic killIn,
   input wire logic cmpOut,
   input wire logic pwmHigh,
   input wire logic pwmLow
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // ****************
   // pwm and kill
   // ****************
   a_pwm_never_both: assert property (!(pwmHigh && pwmLow))
      else $error("pwm outputs high together");
   a_gap_after_high: assert property ($fell(pwmHigh) |-> !pwmLow [*2])
      else $error("low output rose inside deadband");
   a_gap_after_low: assert property ($fell(pwmLow) |-> !pwmHigh [*2])
      else $error("high output rose inside deadband");
   a_kill_blocks_out: assert property (killIn [*3] |=> !cmpOut && !pwmHigh && !pwmLow)
      else $error("outputs active while killed");
   // ****************
   // register bus
   // ****************
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write response late");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address taken during response");
   a_resp_one_beat: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken during data");
endmodule
bind tcp_timer tcp_timer_checker i_chk (.sys_clk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .killIn, .cmpOut, .pwmHigh, .pwmLow);

// ### tb_top.sv
// Purpose: self-checking bench for the timer, counter and pwm block
// Assumes: registers over axi4-lite, routed inputs through the route model
// Notes:   bready and rready held high, full-word strobes
`include "tcp_regs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rrv, brv;
   logic        enCmd, rstCmd, capCmd, killCmd, extRun;
   logic        timerEnable, timerReset, captureIn, killIn, extClock, cmpOut, tcOut, pwmHigh, pwmLow, irq;
   logic [4:0]  cmpExp;
   int          n_errors, n_checks, i, cycles = 0;
   tcp_route_model i_route (.sys_clk, .resetn, .enCmd, .rstCmd, .capCmd, .killCmd, .extRun,
      .timerEnable, .timerReset, .captureIn, .killIn, .extClock);
   tcp_timer i_dut (.sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .timerEnable, .timerReset, .captureIn, .killIn, .extClock, .cmpOut, .tcOut,
      .pwmHigh, .pwmLow, .irq);
   // ****************
   // bus tasks
   // ****************
   // write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do begin
         @(negedge sys_clk);
         aw = s_axi_awvalid & s_axi_awready;
         w = s_axi_wvalid & s_axi_wready;
         b = s_axi_bvalid;
         brv = s_axi_bresp;
         @(posedge sys_clk);
         if (aw) s_axi_awvalid <= 1'h0;
         if (w) s_axi_wvalid <= 1'h0;
      end while (!b);
   endtask
   // read: data and response kept at the edge that takes them
   task automatic rd(input logic [7:0] a);
      logic ar, r;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do begin
         @(negedge sys_clk);
         ar = s_axi_arvalid & s_axi_arready;
         r = s_axi_rvalid;
         rdv = s_axi_rdata;
         rrv = s_axi_rresp;
         @(posedge sys_clk);
         if (ar) s_axi_arvalid <= 1'h0;
      end while (!r);
   endtask
   // compare one value
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(nm, e, rdv);
   endtask
   function automatic logic [31:0] ctl(logic [1:0] m, logic [2:0] rel, logic [1:0] cs, logic tc, logic run);
      return {23'h0, tc, cs, rel, m, run};
   endfunction
   // verdict and end of run
   task automatic results;
      if (n_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ****************
   // clock, watchdog, tests
   // ****************
   initial begin
      sys_clk = 1'h0;
      forever #20 sys_clk = ~sys_clk;
   end
   // cut a hang short
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         results();
      end
   end
   // main sequence
   initial begin
      {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, enCmd, rstCmd, capCmd, killCmd, extRun} = 9'h000;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
      {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3F;
      cmpExp = 5'h0E;
      repeat (3) @(posedge sys_clk);
      resetn <= 1'h1;
      @(posedge sys_clk);
      rc("period", `TCP_OFF_PERIOD, 32'h0000_FFFF);
      rc("compare", `TCP_OFF_CMP, 32'h0000_8000);
      rc("count", `TCP_OFF_COUNT, 32'h0000_FFFF);
      rc("deadband", `TCP_OFF_DEADBAND, 32'h0000_0002);
      rc("unmapped", 8'h20, 32'h0000_0000);
      chk("unmapped resp", 2'h2, rrv);
      wr(8'h20, 32'h0000_0001);
      chk("unmapped write resp", 2'h2, brv);
      wr(`TCP_OFF_PERIOD, 32'h0000_0003);
      chk("write resp", 2'h0, brv);
      for (i = 0; i < 4; i++) begin
         extRun <= (i == 3);
         wr(`TCP_OFF_CTRL, ctl(`TCP_MODE_ONESHOT, `TCP_CMP_LT, i[1:0], 1'h0, 1'h0));
         wr(`TCP_OFF_CTRL, ctl(`TCP_MODE_ONESHOT, `TCP_CMP_LT, i[1:0], 1'h0, 1'h1));
         repeat (9) @(posedge sys_clk);
         rd(`TCP_OFF_STATUS);
         chk("early terminal", i < 2, rdv & 32'h0000_0001);
         repeat (200) @(posedge sys_clk);
         rc("oneshot stop", `TCP_OFF_COUNT, 32'h0000_0003);
         rd(`TCP_OFF_STATUS);
         chk("terminal flag", 32'h0000_0001, rdv & 32'h0000_0001);
         wr(`TCP_OFF_STATUS, 32'h0000_0007);
      end
      wr(`TCP_OFF_PERIOD, 32'h0000_000A);
      wr(`TCP_OFF_CMP, 32'h0000_000A);
      wr(`TCP_OFF_CTRL, ctl(`TCP_MODE_GATED, `TCP_CMP_LT, `TCP_CLK_SYS, 1'h0, 1'h0));
      wr(`TCP_OFF_CTRL, ctl(`TCP_MODE_GATED, `TCP_CMP_LT, `TCP_CLK_SYS, 1'h0, 1'h1));
      repeat (20) @(posedge sys_clk);
      rc("gated hold", `TCP_OFF_COUNT, 32'h0000_000A);
      for (i = 4; i >= 0; i--) begin
         wr(`TCP_OFF_CTRL, ctl(`TCP_MODE_GATED, i[2:0], `TCP_CLK_SYS, 1'h1, 1'h1));
         repeat (4) @(posedge sys_clk);
         chk("compare out", cmpExp[i], cmpOut);
         chk("tc pin", !cmpExp[i], tcOut);
      end
      wr(`TCP_OFF_CTRL, ctl(`TCP_MODE_GATED, `TCP_CMP_GTE, `TCP_CLK_SYS, 1'h1, 1'h1));
      repeat (2) @(posedge sys_clk);
      chk("deadband gap", 2'h0, {pwmHigh, pwmLow});
      repeat (2) @(posedge sys_clk);
      chk("pwm high", 2'h2, {pwmHigh, pwmLow});
      chk("live compare", 1'h1, cmpOut);
      killCmd <= 1'h1;
      repeat (5) @(posedge sys_clk);
      chk("killed compare", 1'h0, cmpOut);
      chk("killed pwm", 2'h0, {pwmHigh, pwmLow});
      killCmd <= 1'h0;
      capCmd <= 1'h1;
      repeat (3) @(posedge sys_clk);
      capCmd <= 1'h0;
      repeat (4) @(posedge sys_clk);
      rc("capture", `TCP_OFF_CAPTURE, 32'h0000_000A);
      chk("irq masked", 1'h0, irq);
      wr(`TCP_OFF_MASK, 32'h0000_0004);
      chk("irq capture", 1'h1, irq);
      wr(`TCP_OFF_STATUS, 32'h0000_0004);
      chk("irq cleared", 1'h0, irq);
      enCmd <= 1'h1;
      repeat (6) @(posedge sys_clk);
      enCmd <= 1'h0;
      repeat (4) @(posedge sys_clk);
      rc("gated count", `TCP_OFF_COUNT, 32'h0000_0004);
      rstCmd <= 1'h1;
      repeat (3) @(posedge sys_clk);
      rstCmd <= 1'h0;
      repeat (4) @(posedge sys_clk);
      rc("reset reload", `TCP_OFF_COUNT, 32'h0000_000A);
      wr(`TCP_OFF_CMP, 32'h0000_0005);
      wr(`TCP_OFF_MASK, 32'h0000_0001);
      wr(`TCP_OFF_CTRL, ctl(`TCP_MODE_FREE, `TCP_CMP_LT, `TCP_CLK_SYS, 1'h0, 1'h1));
      repeat (100) @(posedge sys_clk);
      chk("irq terminal", 1'h1, irq);
      rd(`TCP_OFF_COUNT);
      chk("free count range", 1'h1, rdv <= 32'h0000_000A);
      results();
   end
endmodule
